/* File: hw/flash_qpi_host.sv */
// host controller for a serial nor flash over one, two or four lanes
// assumes the flash samples on rising sclk and drives on falling sclk
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "flash_host_defs.svh"

module flash_qpi_host
   import flash_host_pkg::*;
#(
   parameter int HALF_CYC = `SCLK_HALF_CYC,
   parameter int MAX_PROG = `PROG_MAX_BYTES
) (
   // system
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // flash pins
   output logic flash_cs_n,
   output logic flash_sclk,
   output logic [3:0] flash_io_o,
   output logic [3:0] flash_io_oe,
   input wire logic [3:0] flash_io_i
);

   // ==========================================================
   // lane helpers
   function automatic logic [2:0] lanes(input logic [1:0] c);
      case (c)
         2'd1: lanes = 3'd2;
         2'd2: lanes = 3'd4;
         default: lanes = 3'd1;
      endcase
   endfunction

   function automatic logic [4:0] per_byte(input logic [2:0] w);
      case (w)
         3'd4: per_byte = 5'd2;
         3'd2: per_byte = 5'd4;
         default: per_byte = 5'd8;
      endcase
   endfunction

   function automatic logic [3:0] lane_mask(input logic [2:0] w);
      case (w)
         3'd4: lane_mask = 4'hF;
         3'd2: lane_mask = 4'h3;
         default: lane_mask = 4'h1;
      endcase
   endfunction

   // top bits of the field, msb first; odd bits land on the higher lane
   function automatic logic [3:0] lane_out(input logic [7:0] t, input logic [2:0] w);
      case (w)
         3'd4: lane_out = t[7:4];
         3'd2: lane_out = {2'b00, t[7:6]};
         default: lane_out = {3'b000, t[7]};
      endcase
   endfunction

   function automatic logic [23:0] shl(input logic [23:0] s, input logic [2:0] w);
      case (w)
         3'd4: shl = {s[19:0], 4'h0};
         3'd2: shl = {s[21:0], 2'b00};
         default: shl = {s[22:0], 1'b0};
      endcase
   endfunction

   // single lane reads come back on io1
   function automatic logic [7:0] lane_in(input logic [3:0] io, input logic [2:0] w,
                                          input logic [7:0] s);
      case (w)
         3'd4: lane_in = {s[3:0], io};
         3'd2: lane_in = {s[5:0], io[1:0]};
         default: lane_in = {s[6:0], io[1]};
      endcase
   endfunction

   // ==========================================================
   // reset release and pin synchronisers
   logic [1:0] rst_sync_r;
   logic rst_q;
   logic [3:0] io_s1_r;
   logic [3:0] io_s2_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) rst_sync_r <= 2'b00;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_q = rst_sync_r[1];

   always_ff @(posedge sys_clk or negedge rst_q) begin
      if (!rst_q) begin
         io_s1_r <= 4'h0;
         io_s2_r <= 4'h0;
      end else begin
         io_s1_r <= flash_io_i;
         io_s2_r <= io_s1_r;
      end
   end

   // ==========================================================
   // half-period divider
   logic [7:0] div_r;
   logic tick;
   assign tick = div_r == 8'(HALF_CYC - 1);

   always_ff @(posedge sys_clk or negedge rst_q) begin
      if (!rst_q) div_r <= 8'h00;
      else div_r <= tick ? 8'h00 : div_r + 8'h01;
   end

   // ==========================================================
   // registers and state
   state_type st_r;
   cmd_type cmd_r;
   logic [23:0] addr_r;
   logic [7:0] mode_r;
   logic [15:0] len_r;
   logic [7:0] tx_r;
   logic tx_full_r;
   logic [7:0] rx_data_r;
   logic [7:0] rx_sh_r;
   logic rx_full_r;
   logic [7:0] param_r;
   logic qpi_r;
   logic [23:0] shift_r;
   logic [2:0] w_r;
   logic [2:0] aw_r;
   logic [2:0] dw_r;
   logic rd_r;
   logic [3:0] dum_r;
   logic [4:0] clk_left_r;
   logic [15:0] byte_left_r;
   logic cs_n_r;
   logic sclk_r;
   logic [3:0] io_o_r;
   logic [3:0] io_oe_r;
   logic [31:0] rdata_r;

   // ==========================================================
   // register decode
   logic idle;
   logic busy_wr;
   logic start_go;
   logic wr_tx;
   logic rx_take;
   logic [31:0] rd_mux;
   assign idle = st_r == ST_IDLE;
   assign busy_wr = reg_wr && idle;
   assign start_go = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_START] && idle;
   assign wr_tx = reg_wr && reg_addr == `REG_TXDATA;
   assign rx_take = reg_rd && reg_addr == `REG_RXDATA;
   assign rd_mux = reg_addr == `REG_CTRL ? {30'h0, qpi_r, !idle} :
                   reg_addr == `REG_CMD ? {13'h0, cmd_r} :
                   reg_addr == `REG_ADDR ? {8'h00, addr_r} :
                   reg_addr == `REG_MODE ? {24'h0, mode_r} :
                   reg_addr == `REG_LEN ? {16'h0, len_r} :
                   reg_addr == `REG_TXDATA ? {24'h0, tx_r} :
                   reg_addr == `REG_RXDATA ? {24'h0, rx_data_r} :
                   reg_addr == `REG_STATUS ?
                      {16'h0, param_r, 4'h0, rx_full_r, tx_full_r, qpi_r, !idle} :
                   32'h0;

   // ==========================================================
   // effective command
   logic [7:0] op;
   logic is_prog;
   logic is_wrsr;
   logic is_zero_addr;
   logic qpi_read;
   logic [2:0] e_opw;
   logic [3:0] e_dum;
   logic [23:0] e_addr;
   logic [15:0] e_len;
   logic e_has_addr;
   assign op = cmd_r.opcode;
   assign is_prog = op == `OP_PAGE_PROG || op == `OP_QUAD_PROG || op == `OP_SEC_PROG;
   assign is_wrsr = op == `OP_WR_STAT1 || op == `OP_WR_STAT2 || op == `OP_WR_STAT3;
   assign is_zero_addr = op == `OP_MFR_ID || op == `OP_WAKE_ID;
   assign qpi_read = qpi_r && (op == `OP_FAST_READ || op == `OP_QUAD_IO_READ ||
                               op == `OP_WRAP_READ);
   assign e_opw = qpi_r ? 3'd4 : 3'd1;
   assign e_dum = qpi_read ? param_r[7:4] :
                  op == `OP_QUAD_IO_READ ? `SPI_QUAD_IO_DUMMY :
                  op == `OP_WORD_READ ? `WORD_READ_DUMMY : cmd_r.dummy;
   assign e_addr = is_zero_addr ? 24'h0 :
                   op == `OP_WORD_READ ? {addr_r[23:1], 1'b0} :
                   op == `OP_OCTAL_READ ? {addr_r[23:4], 4'h0} : addr_r;
   assign e_len = is_prog ? (len_r == 16'h0 ? 16'h1 :
                             len_r > 16'(MAX_PROG) ? 16'(MAX_PROG) : len_r) :
                  (is_wrsr || op == `OP_SET_PARAM) ? 16'h1 : len_r;
   assign e_has_addr = cmd_r.has_addr || is_zero_addr;

   // ==========================================================
   // phase chain and clock events
   state_type sq_dat;
   state_type sq_dum;
   state_type sq_mod;
   state_type sq_adr;
   state_type nx;
   logic run;
   logic fall_go;
   logic rise_go;
   logic phase_end;
   logic cont;
   logic reload_wr;
   logic reload_rd;
   assign sq_dat = byte_left_r != 16'h0 ? ST_DAT : ST_END;
   assign sq_dum = dum_r != 4'h0 ? ST_DUM : sq_dat;
   assign sq_mod = cmd_r.has_mode ? ST_MOD : sq_dum;
   assign sq_adr = e_has_addr ? ST_ADR : sq_mod;
   assign nx = st_r == ST_OPC ? sq_adr : st_r == ST_ADR ? sq_mod :
               st_r == ST_MOD ? sq_dum : sq_dat;
   assign run = st_r == ST_OPC || st_r == ST_ADR || st_r == ST_MOD ||
                st_r == ST_DUM || st_r == ST_DAT;
   // a data byte not yet loaded holds sclk low; this is the only back-pressure
   assign rise_go = tick && !sclk_r && run && !(st_r == ST_DAT && clk_left_r == 5'd0);
   assign fall_go = tick && sclk_r;
   assign phase_end = fall_go && clk_left_r == 5'd1;
   assign cont = fall_go && clk_left_r > 5'd1;
   assign reload_wr = st_r == ST_DAT && clk_left_r == 5'd0 && !rd_r && tx_full_r;
   assign reload_rd = st_r == ST_DAT && clk_left_r == 5'd0 && rd_r && !rx_full_r;

   // load values for the phase being entered
   state_type tgt;
   logic [23:0] ld_src;
   logic [2:0] ld_w;
   logic [4:0] ld_cnt;
   logic [3:0] ld_oe;
   assign tgt = start_go ? ST_OPC : (reload_wr || reload_rd) ? ST_DAT : nx;

   always_comb begin
      ld_src = 24'h0;
      ld_w = dw_r;
      ld_cnt = 5'd0;
      ld_oe = 4'h0;
      case (tgt)
         ST_OPC: begin
            ld_src = {op, 16'h0};
            ld_w = e_opw;
            ld_cnt = per_byte(e_opw);
            ld_oe = lane_mask(e_opw);
         end
         ST_ADR: begin
            ld_src = e_addr;
            ld_w = aw_r;
            ld_cnt = 5'(3 * per_byte(aw_r));
            ld_oe = lane_mask(aw_r);
         end
         ST_MOD: begin
            ld_src = {mode_r, 16'h0};
            ld_w = aw_r;
            ld_cnt = per_byte(aw_r);
            ld_oe = lane_mask(aw_r);
         end
         ST_DUM: begin
            ld_cnt = {1'b0, dum_r};
         end
         ST_DAT: begin
            if (reload_wr || reload_rd) begin
               ld_src = {tx_r, 16'h0};
               ld_cnt = per_byte(dw_r);
               ld_oe = reload_wr ? lane_mask(dw_r) : 4'h0;
            end
         end
         default: begin
            ld_cnt = 5'd0;
         end
      endcase
   end

   // ==========================================================
   // software registers
   always_ff @(posedge sys_clk or negedge rst_q) begin
      if (!rst_q) begin
         cmd_r <= `CMD_RESET;
         addr_r <= 24'h0;
         mode_r <= 8'h00;
         len_r <= 16'h0;
         rdata_r <= 32'h0;
      end else begin
         if (busy_wr && reg_addr == `REG_CMD) cmd_r <= reg_wdata[`CMD_BITS-1:0];
         if (busy_wr && reg_addr == `REG_ADDR) addr_r <= reg_wdata[23:0];
         if (busy_wr && reg_addr == `REG_MODE) mode_r <= reg_wdata[7:0];
         if (busy_wr && reg_addr == `REG_LEN) len_r <= reg_wdata[15:0];
         rdata_r <= reg_rd ? rd_mux : 32'h0;
      end
   end

   // data buffers; a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_q) begin
      if (!rst_q) begin
         tx_r <= 8'h00;
         tx_full_r <= 1'b0;
         rx_full_r <= 1'b0;
         rx_data_r <= 8'h00;
         rx_sh_r <= 8'h00;
         param_r <= `PARAM_RESET;
      end else begin
         if (wr_tx) tx_r <= reg_wdata[7:0];
         tx_full_r <= wr_tx ? 1'b1 : reload_wr ? 1'b0 : tx_full_r;
         if (reload_wr && op == `OP_SET_PARAM) param_r <= tx_r;
         if (rise_go && st_r == ST_DAT && rd_r) begin
            rx_sh_r <= lane_in(io_s2_r, dw_r, rx_sh_r);
            if (clk_left_r == 5'd1) rx_data_r <= lane_in(io_s2_r, dw_r, rx_sh_r);
         end
         rx_full_r <= (rise_go && st_r == ST_DAT && rd_r && clk_left_r == 5'd1) ? 1'b1 :
                      rx_take ? 1'b0 : rx_full_r;
      end
   end

   // ==========================================================
   // sequencer
   always_ff @(posedge sys_clk or negedge rst_q) begin
      if (!rst_q) begin
         st_r <= ST_IDLE;
         qpi_r <= 1'b0;
         shift_r <= 24'h0;
         w_r <= 3'd1;
         aw_r <= 3'd1;
         dw_r <= 3'd1;
         rd_r <= 1'b0;
         dum_r <= 4'h0;
         clk_left_r <= 5'd0;
         byte_left_r <= 16'h0;
         cs_n_r <= 1'b1;
         sclk_r <= 1'b0;
         io_o_r <= 4'h0;
         io_oe_r <= 4'h0;
      end else begin
         sclk_r <= rise_go ? 1'b1 : fall_go ? 1'b0 : sclk_r;
         if (start_go) begin
            cs_n_r <= 1'b0;
            aw_r <= qpi_r ? 3'd4 : lanes(cmd_r.addr_lanes);
            dw_r <= qpi_r ? 3'd4 : lanes(cmd_r.data_lanes);
            rd_r <= cmd_r.rd;
            dum_r <= e_dum;
            byte_left_r <= e_len;
         end
         if (start_go || reload_wr || reload_rd || (phase_end && st_r != ST_DAT)) begin
            st_r <= tgt;
            w_r <= ld_w;
            clk_left_r <= ld_cnt;
            io_o_r <= lane_out(ld_src[23:16], ld_w);
            shift_r <= shl(ld_src, ld_w);
            io_oe_r <= ld_oe;
         end else if (phase_end) begin
            clk_left_r <= 5'd0;
            byte_left_r <= byte_left_r - 16'h1;
            if (byte_left_r == 16'h1) st_r <= ST_END;
         end else if (cont) begin
            clk_left_r <= clk_left_r - 5'd1;
            io_o_r <= lane_out(shift_r[23:16], w_r);
            shift_r <= shl(shift_r, w_r);
         end else if (st_r == ST_END && tick) begin
            cs_n_r <= 1'b1;
            io_oe_r <= 4'h0;
            st_r <= ST_GAP;
            if (op == `OP_QPI_ENTER && !qpi_r) qpi_r <= 1'b1;
            if (op == `OP_QPI_EXIT && qpi_r) qpi_r <= 1'b0;
         end else if (st_r == ST_GAP && tick) begin
            st_r <= ST_IDLE;
         end
      end
   end

   assign flash_cs_n = cs_n_r;
   assign flash_sclk = sclk_r;
   assign flash_io_o = io_o_r;
   assign flash_io_oe = io_oe_r;
   assign reg_rdata = rdata_r;

   // ==========================================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_q);

   sequence start_s;
      start_go;
   endsequence
   sequence end_tick_s;
      st_r == ST_END && tick;
   endsequence

   opc_clocks_a: assert property (start_s |=> clk_left_r == ($past(qpi_r) ? 5'd2 : 5'd8))
      else $error("opcode clock count wrong");
   qpi_enter_a: assert property ((end_tick_s ##0 (op == `OP_QPI_ENTER)) |=> qpi_r)
      else $error("four-lane mode not entered");
   qpi_exit_a: assert property ((end_tick_s ##0 (op == `OP_QPI_EXIT && qpi_r)) |=> !qpi_r)
      else $error("four-lane mode not left");
   quad_addr_map_a: assert property ((cont && st_r == ST_ADR && w_r == 3'd4) |=>
      flash_io_o == $past(shift_r[23:20]) && flash_io_oe == 4'hF)
      else $error("quad address lanes wrong");
   dual_addr_map_a: assert property ((cont && st_r == ST_ADR && w_r == 3'd2) |=>
      flash_io_o[1:0] == $past(shift_r[23:22]) && flash_io_oe == 4'h3)
      else $error("dual address lanes wrong");
   quad_data_map_a: assert property ((cont && st_r == ST_DAT && !rd_r && w_r == 3'd4) |=>
      flash_io_o == $past(shift_r[23:20]))
      else $error("quad data lanes wrong");
   read_release_a: assert property ((st_r == ST_DUM || (st_r == ST_DAT && rd_r)) |->
      flash_io_oe == 4'h0)
      else $error("host drives lanes during read");
   prog_len_a: assert property ((start_s ##0 is_prog) |=>
      byte_left_r >= 16'h1 && byte_left_r <= 16'(MAX_PROG))
      else $error("program length out of range");
   wrsr_len_a: assert property ((start_s ##0 is_wrsr) |=> byte_left_r == 16'h1)
      else $error("status write not one byte");
   word_align_a: assert property ((cont && st_r == ST_ADR && w_r == 3'd4 &&
      op == `OP_WORD_READ && clk_left_r == 5'd2) |=> !flash_io_o[0])
      else $error("word read address bit0 set");
   octal_align_a: assert property ((cont && st_r == ST_ADR && w_r == 3'd4 &&
      op == `OP_OCTAL_READ && clk_left_r == 5'd2) |=> flash_io_o == 4'h0)
      else $error("octal read address low nibble set");
   qpi_dummy_a: assert property ((start_s ##0 qpi_read) |=> dum_r == $past(param_r[7:4]))
      else $error("four-lane dummy count wrong");
   eb_dummy_a: assert property ((start_s ##0 (!qpi_r && op == `OP_QUAD_IO_READ)) |=>
      dum_r == 4'h4)
      else $error("quad io read dummy count wrong");

endmodule

/* File: inc/flash_host_defs.svh */
// register map, field positions, opcodes and timing counts of the flash host
// assumes a 20 MHz system clock and a byte-wide register address
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ==========================================================
// register offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_ADDR 8'h08
`define REG_MODE 8'h0C
`define REG_LEN 8'h10
`define REG_TXDATA 8'h14
`define REG_RXDATA 8'h18
`define REG_STATUS 8'h1C

// ==========================================================
// field positions and reset values
`define CTRL_START 0
`define CMD_BITS 19
`define CMD_RESET 19'h00000
`define PARAM_RESET 8'h00

// ==========================================================
// opcodes the host treats specially
`define OP_FAST_READ 8'h0B
`define OP_WRAP_READ 8'h0C
`define OP_QUAD_IO_READ 8'hEB
`define OP_WORD_READ 8'hE7
`define OP_OCTAL_READ 8'hE3
`define OP_PAGE_PROG 8'h02
`define OP_QUAD_PROG 8'h32
`define OP_SEC_PROG 8'h42
`define OP_WR_STAT1 8'h01
`define OP_WR_STAT2 8'h31
`define OP_WR_STAT3 8'h11
`define OP_MFR_ID 8'h90
`define OP_WAKE_ID 8'hAB
`define OP_SET_PARAM 8'hC0
`define OP_QPI_ENTER 8'h38
`define OP_QPI_EXIT 8'hFF

// ==========================================================
// timing
`define SYS_CLK_NS 50
`define SCLK_HALF_NS 200
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define PROG_MAX_BYTES 256
`define SPI_QUAD_IO_DUMMY 4'h4
`define WORD_READ_DUMMY 4'h2

`endif

/* File: inc/flash_host_pkg.sv */
// types shared by the flash host and its bench
// assumes flash_host_defs.svh is included by the user of the package
package flash_host_pkg;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADR, ST_MOD, ST_DUM, ST_DAT, ST_END, ST_GAP
   } state_type;

   // ==========================================================
   // command word; lane codes 0 one lane, 1 two lanes, 2 four lanes
   typedef struct packed {
      logic [3:0] dummy;
      logic rd;
      logic [1:0] data_lanes;
      logic [1:0] addr_lanes;
      logic has_mode;
      logic has_addr;
      logic [7:0] opcode;
   } cmd_type;

endpackage

/* File: test/flash_model.sv */
// behavioural serial nor flash seen from its pins, partner of the host bench
// assumes sclk idles low; the host samples rising sclk, this model drives on falling sclk
`timescale 1ns/100ps

module flash_model (
   // flash pins
   input wire logic flash_cs_n,
   input wire logic flash_sclk,
   input wire logic [3:0] flash_io_o,
   output logic [3:0] dev_o,
   // read setup from the bench
   input wire logic [7:0] rd_byte,
   input wire logic [15:0] data_start,
   input wire logic [1:0] lanes,
   // observation
   output logic [15:0] nclk
);
   logic [3:0] cap [0:1023];
   logic [7:0] page [0:255];
   logic [7:0] pg_sh;
   logic [7:0] pg_at;
   int pw;
   logic [7:0] v;
   int k;
   int w;

   // ==========================================================
   // capture of every clock of a frame
   initial begin
      dev_o = 4'h5;
      nclk = 16'h0000;
      pg_sh = 8'h00;
      pg_at = 8'h00;
   end
   always @(negedge flash_cs_n) begin
      nclk = 16'h0000;
   end
   always @(posedge flash_sclk) begin
      if (!flash_cs_n) begin
         cap[nclk] = flash_io_o;
         // the byte shifted in just before data is the low address byte: the page offset
         if (nclk == data_start) pg_at = pg_sh;
         pw = 1 << lanes;
         pg_sh = 8'(pg_sh << pw) | 8'(flash_io_o & 4'((1 << pw) - 1));
         if (nclk >= data_start && (nclk - data_start) % (8 / pw) == 8 / pw - 1) begin
            page[pg_at] = pg_sh;
            pg_at = pg_at + 8'h01;
         end
         nclk = nclk + 16'h0001;
      end
   end

   // ==========================================================
   // answer: the byte repeats until deselect; before data every lane toggles and lanes unused in data read 0, so stale data never passes
   always @(negedge flash_sclk or posedge flash_cs_n) begin
      if (!flash_cs_n && nclk >= data_start) begin
         k = int'(nclk - data_start);
         w = 1 << lanes;
         v = 8'(rd_byte << ((k % (8 / w)) * w));
         dev_o = (w == 1) ? {2'b00, v[7], 1'b0} : (w == 2) ? {2'b00, v[7:6]} : v[7:4];
      end else begin
         dev_o = ~dev_o;
      end
   end
endmodule

/* File: test/test_flash_qpi_host.sv */
// self-checking bench of the flash host: register port driven here, flash model on the pins
// assumes the host package and defines header are on the include path
`timescale 1ns/100ps
`include "flash_host_defs.svh"

module test_flash_qpi_host;
   import flash_host_pkg::*;
   logic sys_clk, rst_n, reg_wr, reg_rd;
   logic [7:0] reg_addr, rbyte, md, p;
   logic [31:0] reg_wdata, reg_rdata, s, seed;
   logic flash_cs_n, flash_sclk;
   logic [3:0] flash_io_o, flash_io_oe, flash_io_i, dev_o;
   logic [15:0] dstart, nclk;
   logic [1:0] dlanes;
   logic [7:0] txb [0:255];
   logic [7:0] ops [$];
   logic [23:0] a, sa;
   // every writable bit of the second status byte set, the quad enable flag among them
   localparam logic [7:0] QUAD_ENABLE_BYTE = 8'hFF;
   int n_mismatch = 0;
   int cmp_count = 0;

   // ==========================================================
   // design, partner and the shared io wires
   assign flash_io_i = (flash_io_oe & flash_io_o) | (~flash_io_oe & dev_o);
   flash_qpi_host flash_qpi_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk), .flash_io_o(flash_io_o),
      .flash_io_oe(flash_io_oe), .flash_io_i(flash_io_i));
   flash_model flash_model_inst (.flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk),
      .flash_io_o(flash_io_o), .dev_o(dev_o), .rd_byte(rbyte), .data_start(dstart),
      .lanes(dlanes), .nclk(nclk));

   initial sys_clk = 1'b0;
   always #25 sys_clk = ~sys_clk;

   // ==========================================================
   // checking and closing
   task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_lane(input string nm, input logic [3:0] e, input logic [3:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #5000000;
      n_mismatch++;
      conclude();
   end

   // ==========================================================
   // register port and transfers
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // bounded wait for a status bit
   task automatic poll(input int b, input logic v);
      logic [31:0] st;
      int k;
      for (k = 0; k < 3000; k++) begin
         rd(`REG_STATUS, st);
         if (st[b] === v) break;
      end
      if (k == 3000) cmp_lane("status wait", {3'b000, v}, {3'b000, st[b]});
   endtask
   function automatic cmd_type mk(input logic [7:0] op, input int ha, hm, al, dl, r, d);
      mk = '{dummy: 4'(d), rd: 1'(r), data_lanes: 2'(dl), addr_lanes: 2'(al),
             has_mode: 1'(hm), has_addr: 1'(ha), opcode: op};
   endfunction
   function automatic logic [31:0] clocks(input int ds, input int nb, input logic [1:0] dl);
      clocks = 32'(ds + nb * (8 >> dl));
   endfunction
   // one frame: nb data bytes, ds is the clock at which data begins
   task automatic xfer(input cmd_type c, input logic [23:0] ad, input logic [15:0] len,
                       input int nb, input int ds);
      logic [31:0] r;
      rbyte <= 8'($random(seed));
      dstart <= 16'(ds);
      dlanes <= c.data_lanes;
      wr(`REG_ADDR, {8'h00, ad});
      wr(`REG_MODE, {24'h000000, md});
      wr(`REG_LEN, {16'h0000, len});
      wr(`REG_CMD, {13'h0000, c});
      wr(`REG_CTRL, 32'h00000001);
      for (int i = 0; i < nb; i++) begin
         if (c.rd) begin
            poll(3, 1'b1);
            rd(`REG_RXDATA, r);
            cmp32("rx byte", {24'h000000, rbyte}, r);
         end else begin
            poll(2, 1'b0);
            wr(`REG_TXDATA, {24'h000000, txb[i]});
         end
      end
      poll(0, 1'b0);
      cmp32("sclk count", clocks(ds, nb, c.data_lanes), {16'h0000, nclk});
   endtask
   // lanes seen on the wire against a value sent msb first on w lanes
   task automatic chk(input int st, input logic [31:0] v, input int nb, input int w);
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      for (int i = 0; i < nb / w; i++)
         cmp_lane("lanes", 4'(v >> (nb - (i + 1) * w)) & m, flash_model_inst.cap[st + i] & m);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      seed = 32'h633AE17A;
      {reg_addr, reg_wdata, reg_wr, reg_rd, rbyte, dstart, dlanes, md} = '0;
      rst_n = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(`REG_STATUS, s);
      cmp32("status at reset", 32'h00000000, s);
      rd(8'h40, s);
      cmp32("unmapped read", 32'h00000000, s);
      md = 8'($random(seed));
      a = 24'($random(seed));
      xfer(mk(8'h06, 0, 0, 0, 0, 0, 0), 24'h0, 16'h0, 0, 8);
      chk(0, 32'h06, 8, 1);
      txb[0] = QUAD_ENABLE_BYTE;
      xfer(mk(8'h31, 0, 0, 0, 0, 0, 0), 24'h0, 16'h1, 1, 8);
      chk(8, {24'h0, QUAD_ENABLE_BYTE}, 8, 1);
      xfer(mk(8'h38, 0, 0, 0, 0, 0, 0), 24'h0, 16'h0, 0, 8);
      rd(`REG_STATUS, s);
      cmp32("four lane flag", 32'h1, {31'h0, s[1]});
      xfer(mk(8'h05, 0, 0, 2, 2, 1, 0), 24'h0, 16'h3, 3, 2);
      chk(0, 32'h05, 8, 4);
      ops = {8'h06, 8'h50, 8'h04, 8'hB9, 8'h7E, 8'h98};
      foreach (ops[j]) begin
         xfer(mk(ops[j], 0, 0, 2, 2, 0, 0), a, 16'h0, 0, 2);
         chk(0, {24'h0, ops[j]}, 8, 4);
      end
      p = 8'h30 | (8'($random(seed)) & 8'h4F);
      ops = {8'h01, 8'h31, 8'h11, 8'hC0};
      foreach (ops[j]) begin
         txb[0] = p;
         xfer(mk(ops[j], 0, 0, 2, 2, 0, 0), a, 16'h5, 1, 2);
         chk(2, {24'h0, p}, 8, 4);
      end
      rd(`REG_STATUS, s);
      cmp32("read parameter", {24'h0, p}, {24'h0, s[15:8]});
      ops = {8'h0B, 8'h0C};
      foreach (ops[j]) begin
         xfer(mk(ops[j], 1, 0, 2, 2, 1, 0), a, 16'h2, 2, 8 + p[7:4]);
         chk(2, {8'h0, a}, 24, 4);
      end
      ops = {8'h90, 8'hAB};
      foreach (ops[j]) begin
         xfer(mk(ops[j], 0, 0, 2, 2, 1, 0), a, 16'h2, 2, 8);
         chk(2, 32'h0, 24, 4);
      end
      xfer(mk(8'h9F, 0, 0, 2, 2, 1, 0), a, 16'h3, 3, 2);
      ops = {8'h36, 8'h39, 8'h3D};
      foreach (ops[j]) begin
         xfer(mk(ops[j], 1, 0, 2, 2, ops[j] == 8'h3D, 0), a, 16'(ops[j] == 8'h3D),
              ops[j] == 8'h3D, 8);
         chk(2, {8'h0, a}, 24, 4);
      end
      foreach (txb[i]) txb[i] = 8'($random(seed));
      xfer(mk(8'h02, 1, 0, 2, 2, 0, 0), a, 16'd300, 256, 8);
      for (int i = 0; i < 256; i++) begin
         chk(8 + 2 * i, {24'h0, txb[i]}, 8, 4);
         cmp32("page byte", {24'h0, txb[i]},
               {24'h0, flash_model_inst.page[8'(a[7:0] + i)]});
      end
      sa = {8'h00, 2'b00, 2'($random(seed)), 4'h0, a[7:0]};
      xfer(mk(8'h42, 1, 0, 2, 2, 0, 0), sa, 16'h1, 1, 8);
      chk(2, {8'h0, sa}, 24, 4);
      cmp32("security byte", {24'h0, txb[0]},
            {24'h0, flash_model_inst.page[sa[7:0]]});
      xfer(mk(8'hFF, 0, 0, 2, 2, 0, 0), 24'h0, 16'h0, 0, 2);
      rd(`REG_STATUS, s);
      cmp32("four lane flag", 32'h0, {31'h0, s[1]});
      xfer(mk(8'h05, 0, 0, 0, 0, 1, 0), 24'h0, 16'h2, 2, 8);
      xfer(mk(8'hEB, 1, 1, 2, 2, 1, 4), a, 16'h2, 2, 20);
      chk(8, {8'h0, a}, 24, 4);
      chk(14, {24'h0, md}, 8, 4);
      xfer(mk(8'hE7, 1, 1, 2, 2, 1, 2), a | 24'h000001, 16'h2, 2, 18);
      chk(8, {8'h0, a & 24'hFFFFFE}, 24, 4);
      xfer(mk(8'hE3, 1, 1, 2, 2, 1, 0), a | 24'h00000F, 16'h2, 2, 16);
      chk(8, {8'h0, a & 24'hFFFFF0}, 24, 4);
      xfer(mk(8'hBB, 1, 1, 1, 1, 1, 0), a, 16'h2, 2, 24);
      chk(8, {8'h0, a}, 24, 2);
      chk(20, {24'h0, md}, 8, 2);
      conclude();
   end
endmodule
